// ==== src/bscan_map.svh ====
// offsets, opcodes, lengths and timing counts of the boundary-scan link
`ifndef BSCAN_MAP_SVH
`define BSCAN_MAP_SVH
`define POS_CNT 101
`define CELL_CNT 202
`define IR_LEN 4
`define ID_LEN 32
`define LEN_W 8
`define OP_EXTEST 4'h0
`define OP_SAMPLE 4'h1
`define OP_IDCODE 4'h2
`define OP_HIGHZ 4'h8
`define OP_BYPASS 4'hf
`define IR_RESET 4'h2
`define IR_CAPTURE 4'h1
`define TCK_RISE_PH 3'h3
`define TCK_FALL_PH 3'h7
`endif

// ==== src/bscan_pkg.sv ====
// types shared by both ends of the boundary-scan link
package bscan_pkg;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;
endpackage : bscan_pkg

// ==== src/bscan_link_if.sv ====
// the four-wire test link plus reset and output enable of the serial output
`timescale 1ns/1ps
interface bscan_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  logic tdo;
  logic tdo_oe;
  modport device (input tck, input tms, input tdi, input trst_n, output tdo, output tdo_oe);
  modport tester (output tck, output tms, output tdi, output trst_n, input tdo, input tdo_oe);
endinterface : bscan_link_if

// ==== src/tap_next.sv ====
// next-state function of the sixteen-state test access port controller
`timescale 1ns/1ps
module tap_next (
  input wire bscan_pkg::tap_state_t state,
  input wire logic tms,
  output bscan_pkg::tap_state_t next_state
);
  always_comb begin
    unique case (state)
      bscan_pkg::TAP_RESET: next_state = tms ? bscan_pkg::TAP_RESET : bscan_pkg::TAP_IDLE;
      bscan_pkg::TAP_IDLE: next_state = tms ? bscan_pkg::SEL_DR : bscan_pkg::TAP_IDLE;
      bscan_pkg::SEL_DR: next_state = tms ? bscan_pkg::SEL_IR : bscan_pkg::CAP_DR;
      bscan_pkg::CAP_DR: next_state = tms ? bscan_pkg::EX1_DR : bscan_pkg::SH_DR;
      bscan_pkg::SH_DR: next_state = tms ? bscan_pkg::EX1_DR : bscan_pkg::SH_DR;
      bscan_pkg::EX1_DR: next_state = tms ? bscan_pkg::UPD_DR : bscan_pkg::PAU_DR;
      bscan_pkg::PAU_DR: next_state = tms ? bscan_pkg::EX2_DR : bscan_pkg::PAU_DR;
      bscan_pkg::EX2_DR: next_state = tms ? bscan_pkg::UPD_DR : bscan_pkg::SH_DR;
      bscan_pkg::UPD_DR: next_state = tms ? bscan_pkg::SEL_DR : bscan_pkg::TAP_IDLE;
      bscan_pkg::SEL_IR: next_state = tms ? bscan_pkg::TAP_RESET : bscan_pkg::CAP_IR;
      bscan_pkg::CAP_IR: next_state = tms ? bscan_pkg::EX1_IR : bscan_pkg::SH_IR;
      bscan_pkg::SH_IR: next_state = tms ? bscan_pkg::EX1_IR : bscan_pkg::SH_IR;
      bscan_pkg::EX1_IR: next_state = tms ? bscan_pkg::UPD_IR : bscan_pkg::PAU_IR;
      bscan_pkg::PAU_IR: next_state = tms ? bscan_pkg::EX2_IR : bscan_pkg::PAU_IR;
      bscan_pkg::EX2_IR: next_state = tms ? bscan_pkg::UPD_IR : bscan_pkg::SH_IR;
      bscan_pkg::UPD_IR: next_state = tms ? bscan_pkg::SEL_DR : bscan_pkg::TAP_IDLE;
    endcase
  end
endmodule : tap_next

// ==== src/bscan_device.sv ====
// device end: tap controller, instruction, bypass, identification and boundary registers
`timescale 1ns/1ps
`include "bscan_map.svh"
module bscan_device #(
  parameter logic [`ID_LEN-1:0] IDCODE_VALUE = 32'h0000_0001 // arbitrary value
) (
  bscan_link_if.device link,
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [`POS_CNT-1:0] sys_out,
  input wire logic [`POS_CNT-1:0] sys_oe,
  input wire logic [`POS_CNT-1:0] pin_in,
  input wire logic float_all_outputs_n,
  output logic [`POS_CNT-1:0] pin_out,
  output logic [`POS_CNT-1:0] pin_oe,
  output logic on_circuit_emulation_mode
);
  // ---- test clock domain ----
  bscan_pkg::tap_state_t state;
  bscan_pkg::tap_state_t next_state;
  logic [`IR_LEN-1:0] ir_sr;
  logic [`IR_LEN-1:0] ir;
  logic bypass;
  logic [`ID_LEN-1:0] id_sr;
  logic [`CELL_CNT-1:0] bs_sr;
  logic [`CELL_CNT-1:0] bs_upd;
  logic [`CELL_CNT-1:0] bs_cap;
  logic [`POS_CNT-1:0] pin_s1;
  logic [`POS_CNT-1:0] pin_s2;
  logic extest_q;
  logic highz_q;
  logic upd_tgl;
  logic tdo;
  logic tdo_oe;

  tap_next u_tap (
    .state(state),
    .tms(link.tms),
    .next_state(next_state)
  );

  wire logic st_tlr = state == bscan_pkg::TAP_RESET;
  wire logic st_cap_ir = state == bscan_pkg::CAP_IR;
  wire logic st_sh_ir = state == bscan_pkg::SH_IR;
  wire logic st_upd_ir = state == bscan_pkg::UPD_IR;
  wire logic st_cap_dr = state == bscan_pkg::CAP_DR;
  wire logic st_sh_dr = state == bscan_pkg::SH_DR;
  wire logic st_upd_dr = state == bscan_pkg::UPD_DR;

  wire logic is_id = ir == `OP_IDCODE;
  wire logic is_samp = ir == `OP_SAMPLE;
  wire logic is_ext = ir == `OP_EXTEST;
  wire logic is_hz = ir == `OP_HIGHZ;
  wire logic sel_bs = is_samp | is_ext;
  // bypass opcode, high-impedance opcode and every unknown code share the one-stage path
  wire logic sel_byp = !(is_id | sel_bs);

  wire logic dr_out = is_id ? id_sr[0] : (sel_bs ? bs_sr[`CELL_CNT-1] : bypass);

  // position i: control cell at 2i, data cell at 2i+1, so position 0 meets the input first
  for (genvar i = 0; i < `POS_CNT; i++) begin : g_cap
    assign bs_cap[2*i] = bs_upd[2*i];
    assign bs_cap[2*i+1] = pin_s2[i];
  end

  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      state <= bscan_pkg::TAP_RESET;
    end else begin
      state <= next_state;
    end
  end

  // board pins come from outside the test clock domain
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      ir_sr <= '0;
      ir <= `IR_RESET;
    end else begin
      if (st_cap_ir) begin
        ir_sr <= `IR_CAPTURE;
      end else if (st_sh_ir) begin
        ir_sr <= {link.tdi, ir_sr[`IR_LEN-1:1]};
      end
      if (st_tlr) begin
        ir <= `OP_IDCODE;
      end else if (st_upd_ir) begin
        ir <= ir_sr;
      end
    end
  end

  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      bypass <= 1'b0;
      id_sr <= '0;
    end else if (st_cap_dr) begin
      if (sel_byp) begin
        bypass <= 1'b0;
      end
      if (is_id) begin
        id_sr <= IDCODE_VALUE;
      end
    end else if (st_sh_dr) begin
      if (sel_byp) begin
        bypass <= link.tdi;
      end
      if (is_id) begin
        id_sr <= {link.tdi, id_sr[`ID_LEN-1:1]};
      end
    end
  end

  // float mode never touches this chain, so shifting survives it
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      bs_sr <= '0;
    end else if (st_cap_dr && sel_bs) begin
      bs_sr <= bs_cap;
    end else if (st_sh_dr && sel_bs) begin
      bs_sr <= {bs_sr[`CELL_CNT-2:0], link.tdi};
    end
  end

  // latches keep their value across instruction changes, so a preload survives into the test
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      bs_upd <= '0;
      upd_tgl <= 1'b0;
    end else if (st_upd_dr && sel_bs) begin
      bs_upd <= bs_sr;
      upd_tgl <= !upd_tgl;
    end
  end

  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      extest_q <= 1'b0;
      highz_q <= 1'b0;
    end else begin
      extest_q <= is_ext;
      highz_q <= is_hz;
    end
  end

  always_ff @(negedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo_oe <= st_sh_ir | st_sh_dr;
      tdo <= st_sh_ir ? ir_sr[0] : dr_out;
    end
  end

  assign link.tdo = tdo;
  assign link.tdo_oe = tdo_oe;

  // ---- system clock domain ----
  logic [2:0] tgl_s;
  logic [1:0] ext_s;
  logic [1:0] hz_s;
  logic [1:0] flt_s;
  logic [`CELL_CNT-1:0] drv;
  logic [`POS_CNT-1:0] next_out;
  logic [`POS_CNT-1:0] next_oe;

  // the latch word is copied on a synchronised toggle; it cannot change again for several
  // test clocks, far longer than the two-stage delay, so the copy is always coherent
  wire logic upd_seen = tgl_s[2] != tgl_s[1];
  wire logic floating = !flt_s[1];

  for (genvar i = 0; i < `POS_CNT; i++) begin : g_pin
    assign next_out[i] = ext_s[1] ? drv[2*i+1] : sys_out[i];
    assign next_oe[i] = !floating && !hz_s[1] && (ext_s[1] ? drv[2*i] : sys_oe[i]);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tgl_s <= '0;
      ext_s <= '0;
      hz_s <= '0;
      flt_s <= 2'h3;
    end else begin
      tgl_s <= {tgl_s[1:0], upd_tgl};
      ext_s <= {ext_s[0], extest_q};
      hz_s <= {hz_s[0], highz_q};
      flt_s <= {flt_s[0], float_all_outputs_n};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drv <= '0;
    end else if (upd_seen) begin
      drv <= bs_upd;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe <= '0;
      on_circuit_emulation_mode <= 1'b0;
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      on_circuit_emulation_mode <= floating;
    end
  end
endmodule : bscan_device

// ==== src/bscan_tester.sv ====
// tester end: makes the test clock, walks the controller, runs instruction and data scans
`timescale 1ns/1ps
`include "bscan_map.svh"
module bscan_tester (
  bscan_link_if.tester link,
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_ir,
  input wire logic [`LEN_W-1:0] cmd_len,
  input wire logic [`CELL_CNT-1:0] cmd_data,
  output logic cmd_ready,
  output logic resp_valid,
  output logic [`CELL_CNT-1:0] resp_data
);
  logic [2:0] phase;
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  logic [1:0] tdo_s;
  logic [1:0] oe_s;
  bscan_pkg::tap_state_t state;
  bscan_pkg::tap_state_t next_state;
  logic busy;
  logic job_ir;
  logic [`LEN_W-1:0] len;
  logic [`LEN_W-1:0] cnt;
  logic [`CELL_CNT-1:0] sh;

  tap_next u_track (
    .state(state),
    .tms(tms),
    .next_state(next_state)
  );

  wire logic rise = phase == `TCK_RISE_PH;
  wire logic fall = phase == `TCK_FALL_PH;
  wire logic accept = cmd_valid && cmd_ready;
  wire logic in_shift = state == bscan_pkg::SH_DR || state == bscan_pkg::SH_IR;
  wire logic in_update = state == bscan_pkg::UPD_DR || state == bscan_pkg::UPD_IR;
  wire logic last = cnt == len - `LEN_W'(1);
  // a floating serial output reads as one, as a pull-up would; level and enable are
  // synchronised apart so no logic touches either before its second stage
  wire logic tdo_pin = oe_s[1] ? tdo_s[1] : 1'b1;
  wire logic [`LEN_W-1:0] pad = `LEN_W'(`CELL_CNT) - len;

  // idle -> select-dr -> (select-ir) -> capture -> shift ... exit1 -> update -> idle
  wire logic next_tms =
    (state == bscan_pkg::TAP_IDLE) ? busy :
    (state == bscan_pkg::SEL_DR) ? job_ir :
    in_shift ? last :
    (state == bscan_pkg::EX1_DR || state == bscan_pkg::EX1_IR);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase <= '0;
      tck <= 1'b0;
      trst_n <= 1'b0;
      tdo_s <= '0;
      oe_s <= '0;
    end else begin
      phase <= phase + 3'h1;
      tck <= rise ? 1'b1 : (fall ? 1'b0 : tck);
      trst_n <= 1'b1;
      tdo_s <= {tdo_s[0], link.tdo};
      oe_s <= {oe_s[0], link.tdo_oe};
    end
  end

  // new levels go out with the falling edge so the device sees them settled at the next rise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tms <= 1'b1;
      tdi <= 1'b0;
    end else if (fall) begin
      tms <= next_tms;
      tdi <= in_shift ? sh[0] : 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= bscan_pkg::TAP_RESET;
    end else if (rise) begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cmd_ready <= 1'b1;
      resp_valid <= 1'b0;
      resp_data <= '0;
      job_ir <= 1'b0;
      len <= '0;
      cnt <= '0;
      sh <= '0;
    end else begin
      resp_valid <= 1'b0;
      if (accept) begin
        busy <= 1'b1;
        cmd_ready <= 1'b0;
        job_ir <= cmd_ir;
        len <= cmd_len;
        cnt <= '0;
        sh <= cmd_data;
      end else if (rise && busy && in_shift) begin
        sh <= {tdo_pin, sh[`CELL_CNT-1:1]};
        cnt <= cnt + `LEN_W'(1);
      end else if (rise && busy && in_update) begin
        busy <= 1'b0;
        cmd_ready <= 1'b1;
        resp_valid <= 1'b1;
        resp_data <= sh >> pad;
      end
    end
  end

  assign link.tck = tck;
  assign link.tms = tms;
  assign link.tdi = tdi;
  assign link.trst_n = trst_n;
endmodule : bscan_tester

// ==== testbench/bscan_link_chk.sv ====
// assertions on the four-wire test link, with a local copy of the controller
`timescale 1ns/1ps
module bscan_link_chk #(
  parameter logic [31:0] IDCODE_VALUE = 32'h0a5c_3e01 // arbitrary value
) (
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic [3:0] st;
  logic [3:0] sh;
  logic [3:0] ir;
  logic [7:0] cnt;
  logic [3:0] next_st;
  wire in_shift = (st == 4'h4) || (st == 4'hb);
  wire dr_shift = st == 4'h4;
  wire by_ir = !(ir inside {4'h0, 4'h1, 4'h2, 4'h8});
  // own state graph, kept apart from the design's so a shared slip cannot hide
  always_comb begin
    case (st)
      4'h0: next_st = tms ? 4'h0 : 4'h1;
      4'h1: next_st = tms ? 4'h2 : 4'h1;
      4'h2: next_st = tms ? 4'h9 : 4'h3;
      4'h3, 4'h4: next_st = tms ? 4'h5 : 4'h4;
      4'h5: next_st = tms ? 4'h8 : 4'h6;
      4'h6: next_st = tms ? 4'h7 : 4'h6;
      4'h7: next_st = tms ? 4'h8 : 4'h4;
      4'h9: next_st = tms ? 4'h0 : 4'ha;
      4'ha, 4'hb: next_st = tms ? 4'hc : 4'hb;
      4'hc: next_st = tms ? 4'hf : 4'hd;
      4'hd: next_st = tms ? 4'he : 4'hd;
      4'he: next_st = tms ? 4'hf : 4'hb;
      default: next_st = tms ? 4'h2 : 4'h1;
    endcase
  end
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      st <= 4'h0;
      sh <= 4'h0;
      ir <= 4'h2;
      cnt <= 8'h00;
    end else begin
      st <= next_st;
      cnt <= in_shift ? cnt + 8'h01 : 8'h00;
      sh <= (st == 4'hb) ? {tdi, sh[3:1]} : sh;
      ir <= (st == 4'h0) ? 4'h2 : (st == 4'hf) ? sh : ir;
    end
  end
  default clocking cb @(posedge tck); endclocking
  default disable iff (!trst_n);
  property p_oe_shift; tdo_oe == in_shift; endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("output enable outside shift");
  property p_ir_first; (st == 4'hb && cnt == 8'h00) |-> tdo; endproperty
  a_ir_first: assert property (p_ir_first) else $error("first captured bit not one");
  property p_ir_rest; (st == 4'hb && cnt inside {[8'h01:8'h03]}) |-> !tdo; endproperty
  a_ir_rest: assert property (p_ir_rest) else $error("upper captured bits not zero");
  property p_byp_zero; (dr_shift && by_ir && cnt == 8'h00) |-> !tdo; endproperty
  a_byp_zero: assert property (p_byp_zero) else $error("bypass capture not zero");
  property p_hz_zero; (dr_shift && ir == 4'h8 && cnt == 8'h00) |-> !tdo; endproperty
  a_hz_zero: assert property (p_hz_zero) else $error("high-z capture not zero");
  property p_byp_delay; (dr_shift && (by_ir || ir == 4'h8) && cnt != 8'h00) |-> tdo == $past(tdi); endproperty
  a_byp_delay: assert property (p_byp_delay) else $error("bypass path not one stage");
  property p_id_bits; (dr_shift && ir == 4'h2 && cnt < 8'h20) |-> tdo == IDCODE_VALUE[cnt[4:0]]; endproperty
  a_id_bits: assert property (p_id_bits) else $error("identification bit wrong");
  property p_oe_reset; $rose(trst_n) |-> !tdo_oe ##1 !tdo_oe; endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("output driven after test reset");
  c_ir_load: cover property (st == 4'hf);
  c_chain: cover property (dr_shift && ir == 4'h0 && cnt == 8'hc9);
  c_bypass: cover property (dr_shift && by_ir && cnt == 8'h07);
endmodule : bscan_link_chk

// ==== testbench/boundary_scan_test_logic_tb.sv ====
// self-checking bench: tester end drives the device end across the link
`timescale 1ns/1ps
module boundary_scan_test_logic_tb;
  localparam logic [31:0] ID = 32'h0a5c_3e01; // arbitrary value
  localparam logic [15:0] OPS = 16'h285f;
  logic clk_sys, rst, cmd_valid, cmd_ir, cmd_ready, resp_valid;
  logic float_all_outputs_n, on_circuit_emulation_mode;
  logic [7:0] cmd_len;
  logic [201:0] cmd_data, resp_data, lat, d;
  logic [100:0] sys_out, sys_oe, pin_in, pin_out, pin_oe, p;
  logic [201:0] exp_q[$];
  logic [31:0] seed;
  logic [3:0] op;
  int n_mismatch;
  int checks_done;
  bscan_link_if link();
  bscan_device #(.IDCODE_VALUE(ID)) i_bscan_device(.link(link), .clk_sys(clk_sys), .rst(rst),
    .sys_out(sys_out), .sys_oe(sys_oe), .pin_in(pin_in), .float_all_outputs_n(float_all_outputs_n),
    .pin_out(pin_out), .pin_oe(pin_oe), .on_circuit_emulation_mode(on_circuit_emulation_mode));
  bscan_tester i_bscan_tester(.link(link), .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ir(cmd_ir), .cmd_len(cmd_len), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .resp_valid(resp_valid), .resp_data(resp_data));
  bscan_link_chk #(.IDCODE_VALUE(ID)) i_bscan_link_chk(.tck(link.tck), .tms(link.tms), .tdi(link.tdi),
    .trst_n(link.trst_n), .tdo(link.tdo), .tdo_oe(link.tdo_oe));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [201:0] r202();
    logic [223:0] r;
    for (int k = 0; k < 7; k++) r = {r[191:0], rnd()};
    return r[201:0];
  endfunction : r202
  function automatic logic [201:0] rev(input logic [201:0] x);
    logic [201:0] y;
    for (int k = 0; k < 202; k++) y[k] = x[201 - k];
    return y;
  endfunction : rev
  // control cell of position k is chain bit 2k, data cell 2k+1
  function automatic logic [100:0] cells(input logic [201:0] x, input int s);
    logic [100:0] y;
    for (int k = 0; k < 101; k++) y[k] = x[2 * k + s];
    return y;
  endfunction : cells
  // capture keeps control latches, data cells take pins; last chain bit leaves first
  function automatic logic [201:0] capt(input logic [201:0] l, input logic [100:0] q);
    logic [201:0] y;
    y = l;
    for (int k = 0; k < 101; k++) y[2 * k + 1] = q[k];
    return rev(y);
  endfunction : capt
  task automatic check(input logic [201:0] got, input logic [201:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic scan(input logic ir, input logic [7:0] n, input logic [201:0] dat, input logic [201:0] e);
    bit seen;
    seen = 1'b0;
    exp_q.push_back(e);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_ir <= ir;
    cmd_len <= n;
    cmd_data <= dat;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    repeat (4000) begin
      @(posedge clk_sys);
      if (resp_valid === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    // a scan that never answers ends the run as a failure
    if (!seen) begin
      n_mismatch++;
      summarize();
    end
  endtask : scan
  task automatic load_ir(input logic [3:0] o);
    scan(1'b1, 8'h04, {198'h0, o}, 202'h1);
  endtask : load_ir
  task automatic byp();
    d = r202();
    scan(1'b0, 8'h08, 202'(d[7:0]), 202'({d[6:0], 1'b0}));
  endtask : byp
  task automatic pins(input logic [100:0] eo, input logic [100:0] eoe, input logic [100:0] m);
    repeat (8) @(posedge clk_sys);
    check(202'(pin_out & m), 202'(eo & m));
    check(202'(pin_oe), 202'(eoe));
  endtask : pins
  // new pin levels need two test clocks through the synchroniser before capture
  task automatic new_pins();
    p = 101'(r202());
    pin_in <= p;
    repeat (40) @(posedge clk_sys);
  endtask : new_pins
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  always @(posedge clk_sys) begin
    if (resp_valid === 1'b1) check(resp_data, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
  end
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // the whole run needs about 7k cycles; this leaves ample margin
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
  initial begin
    seed = 32'h0000_0048;
    n_mismatch = 0;
    checks_done = 0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_ir = 1'b0;
    cmd_len = 8'h00;
    cmd_data = '0;
    float_all_outputs_n = 1'b1;
    sys_out = 101'(r202());
    sys_oe = 101'(r202());
    pin_in = '0;
    lat = '0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    scan(1'b0, 8'h20, r202(), 202'(ID));
    pins(sys_out, sys_oe, '1);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      op = OPS[4 * k +: 4];
      load_ir(op);
      if (op == 4'h2) scan(1'b0, 8'h20, r202(), 202'(ID));
      else byp();
      if (op == 4'h8) pins(sys_out, '0, '0);
    end
    $display("test instructions done");
    new_pins();
    load_ir(4'h1);
    d = r202();
    scan(1'b0, 8'hca, d, capt(lat, p));
    lat = rev(d);
    pins(sys_out, sys_oe, '1);
    $display("test sample done");
    load_ir(4'h0);
    repeat (2) begin
      new_pins();
      d = r202();
      scan(1'b0, 8'hca, d, capt(lat, p));
      lat = rev(d);
      pins(cells(lat, 1), cells(lat, 0), cells(lat, 0));
    end
    $display("test extest done");
    float_all_outputs_n <= 1'b0;
    pins(sys_out, '0, '0);
    check(202'(on_circuit_emulation_mode), 202'h1);
    load_ir(4'hf);
    byp();
    float_all_outputs_n <= 1'b1;
    pins(sys_out, sys_oe, '1);
    check(202'(on_circuit_emulation_mode), 202'h0);
    $display("test float done");
    summarize();
  end
endmodule : boundary_scan_test_logic_tb
